// File: core/cor_config_reg.sv
/*
 * Monitor and comparator configuration register with its control outputs.
 * Assumes the SMBus protocol engine on the same clock decodes each transfer
 * into one-cycle read or write strobes with the command code, and that the
 * low power mode level comes from the first charge option register on the
 * same clock.
 */
`timescale 1ns/1ps

module cor_config_reg
   import cor_pkg::*;
#(
   parameter int unsigned SHIP_CYCLES = COR_SHIP_CYCLES
) (
   input  wire logic      ref_clk,
   input  wire logic      rstn,
   input  wire cor_req_s  req,
   input  wire logic      low_power_mode,
   output cor_rsp_s       rsp,
   output cor_ctrl_s      ctrl
);

   // ****************************************************************
   // State
   // ****************************************************************
   // The reset image of the comparator enable and deglitch, gain and wakeup outputs is taken from
   // the reset word; every other control output resets to zero.
   localparam cor_config_s CFG_RST = cor_config_s'(COR_CONFIG_RESET);

   typedef struct packed {
      cor_config_s cfg;
      logic [31:0] ship_timer;
      cor_rsp_s    rsp;
      cor_ctrl_s   ctrl;
   } cor_state_s;

   cor_state_s st_q;
   cor_state_s st_d;

   logic wr_hit;
   logic rd_hit;
   logic ship_expire;

   assign wr_hit      = req.wr && (req.cmd == COR_CMD_CONFIG);
   assign rd_hit      = req.rd && (req.cmd == COR_CMD_CONFIG);
   assign ship_expire = st_q.cfg.ship_discharge_request
                        && (st_q.ship_timer == SHIP_CYCLES - 1);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_d = st_q;

      // A host write of 1 in the cycle the timer runs out wins and restarts
      // the discharge window; a write of 0 ends it early.
      if (ship_expire) begin
         st_d.cfg.ship_discharge_request = 1'b0;
      end
      if (st_q.cfg.ship_discharge_request) begin
         st_d.ship_timer = st_q.ship_timer + 32'h1;
      end
      if (wr_hit) begin
         st_d.cfg = cor_config_s'(req.wdata);
         if (req.wdata[COR_BIT_SHIP]) begin
            st_d.ship_timer = 32'h0;
         end
      end
      if (!st_d.cfg.ship_discharge_request) begin
         st_d.ship_timer = 32'h0;
      end

      st_d.rsp.valid = req.rd;
      st_d.rsp.hit   = rd_hit;
      st_d.rsp.data  = rd_hit ? 16'(st_q.cfg) : 16'h0000;

      st_d.ctrl.battery_current_output_on =
         st_q.cfg.batt_current_monitor_on && !low_power_mode;
      st_d.ctrl.system_power_output_on =
         st_q.cfg.system_power_monitor_on && !low_power_mode;
      // The reserved alert code is treated as disabled.
      case (st_q.cfg.lowpower_throttle_alert_select)
         COR_ALERT_DCHG_CUR: begin
            st_d.ctrl.throttle_alert_source = COR_ALERT_DCHG_CUR;
         end
         COR_ALERT_SYS_VOLT: begin
            st_d.ctrl.throttle_alert_source = COR_ALERT_SYS_VOLT;
         end
         default: begin
            st_d.ctrl.throttle_alert_source = COR_ALERT_OFF;
         end
      endcase
      st_d.ctrl.input_shunt_select  = st_q.cfg.input_shunt_select;
      st_d.ctrl.charge_shunt_select = st_q.cfg.charge_shunt_select;
      st_d.ctrl.power_monitor_gain  = st_q.cfg.power_monitor_gain;
      st_d.ctrl.comparator_reference_select =
         st_q.cfg.comparator_reference_select;
      st_d.ctrl.comparator_polarity = st_q.cfg.comparator_polarity;
      st_d.ctrl.comparator_on =
         st_q.cfg.comparator_deglitch_select != COR_CMP_OFF;
      st_d.ctrl.comparator_deglitch_select =
         st_q.cfg.comparator_deglitch_select;
      st_d.ctrl.force_latchoff        = st_q.cfg.force_latchoff;
      st_d.ctrl.ship_discharge_active = st_q.cfg.ship_discharge_request;
      st_d.ctrl.auto_wakeup_on        = st_q.cfg.auto_wakeup_on;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // The control outputs lag the register by one cycle so that every
   // output leaves a flip-flop; the reset image matches the reset word.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '{cfg:        CFG_RST,
                   ship_timer: 32'h0,
                   rsp:        '0,
                   ctrl:       '{comparator_on:
                                    CFG_RST.comparator_deglitch_select
                                    != COR_CMP_OFF,
                                 comparator_deglitch_select:
                                    CFG_RST.comparator_deglitch_select,
                                 power_monitor_gain:
                                    CFG_RST.power_monitor_gain,
                                 auto_wakeup_on:
                                    CFG_RST.auto_wakeup_on,
                                 default:                    '0}};
      end else begin
         st_q <= st_d;
      end
   end

   assign rsp  = st_q.rsp;
   assign ctrl = st_q.ctrl;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_write_stores;
      @(posedge ref_clk) disable iff (!rstn)
      wr_hit |=> (16'(st_q.cfg) == $past(req.wdata));
   endproperty
   a_write_stores: assert property (p_write_stores)
      else $error("config write not stored");

   property p_read_returns;
      @(posedge ref_clk) disable iff (!rstn)
      rd_hit |=> (rsp.valid && rsp.hit
                  && rsp.data == $past(16'(st_q.cfg)));
   endproperty
   a_read_returns: assert property (p_read_returns)
      else $error("config read data wrong");

   property p_unmapped_zero;
      @(posedge ref_clk) disable iff (!rstn)
      (req.rd && !rd_hit) |=> (rsp.valid && !rsp.hit && rsp.data == 16'h0);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");

   property p_batt_buffer;
      @(posedge ref_clk) disable iff (!rstn)
      ##1 ctrl.battery_current_output_on
         == ($past(st_q.cfg.batt_current_monitor_on)
             && !$past(low_power_mode));
   endproperty
   a_batt_buffer: assert property (p_batt_buffer)
      else $error("battery monitor buffer wrong");

   property p_sys_power;
      @(posedge ref_clk) disable iff (!rstn)
      low_power_mode |=> !ctrl.system_power_output_on;
   endproperty
   a_sys_power: assert property (p_sys_power)
      else $error("system power on in low power mode");

   property p_alert_source;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q.cfg.lowpower_throttle_alert_select == 2'h3)
         |=> ctrl.throttle_alert_source == COR_ALERT_OFF;
   endproperty
   a_alert_source: assert property (p_alert_source)
      else $error("reserved alert code not disabled");

   property p_shunts_gain;
      @(posedge ref_clk) disable iff (!rstn)
      ##1 ({ctrl.input_shunt_select, ctrl.charge_shunt_select,
            ctrl.power_monitor_gain, ctrl.comparator_reference_select}
           == $past({st_q.cfg.input_shunt_select,
                     st_q.cfg.charge_shunt_select,
                     st_q.cfg.power_monitor_gain,
                     st_q.cfg.comparator_reference_select}));
   endproperty
   a_shunts_gain: assert property (p_shunts_gain)
      else $error("shunt, gain or reference output wrong");

   property p_cmp_enable;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q.cfg.comparator_deglitch_select == COR_CMP_OFF)
         |=> !ctrl.comparator_on;
   endproperty
   a_cmp_enable: assert property (p_cmp_enable)
      else $error("comparator on while disabled");

   property p_ship_clears;
      @(posedge ref_clk) disable iff (!rstn)
      (ship_expire && !(wr_hit && req.wdata[COR_BIT_SHIP]))
         |=> !st_q.cfg.ship_discharge_request ##1
             !ctrl.ship_discharge_active;
   endproperty
   a_ship_clears: assert property (p_ship_clears)
      else $error("ship discharge did not self-clear");

   property p_ship_window;
      @(posedge ref_clk) disable iff (!rstn)
      st_q.ship_timer < SHIP_CYCLES;
   endproperty
   a_ship_window: assert property (p_ship_window)
      else $error("ship timer beyond window");

endmodule

// File: core/cor_pkg.sv
/*
 * Package for the monitor and comparator configuration register: command
 * code, reset value, field layout, timing constants and the carrier structs.
 * Assumes a single 200 MHz clock shared by every user of the package.
 */
package cor_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0]  COR_CMD_CONFIG   = 8'h30;
   localparam logic [15:0] COR_CONFIG_RESET = 16'h0211;

   // Field positions inside the 16-bit word.
   localparam int COR_BIT_BATT_MON    = 15;
   localparam int COR_BIT_ALERT_LO    = 13;
   localparam int COR_BIT_SYS_PWR     = 12;
   localparam int COR_BIT_INPUT_SHUNT = 11;
   localparam int COR_BIT_CHRG_SHUNT  = 10;
   localparam int COR_BIT_GAIN        = 9;
   localparam int COR_BIT_COMPARATOR_REFERENCE_SELECT     = 7;
   localparam int COR_BIT_COMPARATOR_DEGLITCH_SELECT_LO  = 4;
   localparam int COR_BIT_SHIP        = 1;

   localparam logic [15:0] COR_SHIP_MASK = 16'h0002;

   // Throttle alert source codes.
   localparam logic [1:0] COR_ALERT_OFF      = 2'h0;
   localparam logic [1:0] COR_ALERT_DCHG_CUR = 2'h1;
   localparam logic [1:0] COR_ALERT_SYS_VOLT = 2'h2;

   // Comparator deglitch code that switches the comparator off.
   localparam logic [1:0] COR_CMP_OFF = 2'h0;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned COR_CLK_HZ       = 200_000_000;
   localparam int unsigned COR_SHIP_TIME_MS = 140;
   localparam int unsigned COR_SHIP_CYCLES  =
      COR_SHIP_TIME_MS * (COR_CLK_HZ / 1000);

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic       batt_current_monitor_on;
      logic [1:0] lowpower_throttle_alert_select;
      logic       system_power_monitor_on;
      logic       input_shunt_select;
      logic       charge_shunt_select;
      logic       power_monitor_gain;
      logic       reserved_8;
      logic       comparator_reference_select;
      logic       comparator_polarity;
      logic [1:0] comparator_deglitch_select;
      logic       force_latchoff;
      logic       reserved_2;
      logic       ship_discharge_request;
      logic       auto_wakeup_on;
   } cor_config_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  cmd;
      logic [15:0] wdata;
   } cor_req_s;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic [15:0] data;
   } cor_rsp_s;

   typedef struct packed {
      logic       battery_current_output_on;
      logic       system_power_output_on;
      logic [1:0] throttle_alert_source;
      logic       input_shunt_select;
      logic       charge_shunt_select;
      logic       power_monitor_gain;
      logic       comparator_reference_select;
      logic       comparator_polarity;
      logic       comparator_on;
      logic [1:0] comparator_deglitch_select;
      logic       force_latchoff;
      logic       ship_discharge_active;
      logic       auto_wakeup_on;
   } cor_ctrl_s;

endpackage

// File: sim/cor_host_model.sv
/*
 * Host model: stands in for the SMBus engine and issues decoded single-cycle
 * read and write strobes to the configuration register.
 * Assumes the caller enters access() just after a rising clock edge.
 */
`timescale 1ns/1ps

module cor_host_model
   import cor_pkg::*;
(
   input  wire logic ref_clk,
   output cor_req_s  req
);

   initial begin
      req = '0;
   end

   // One idle edge before each strobe keeps a strobe from being lowered and
   // raised again in the same time step.
   // Command and data are scrambled once released, so a design that samples
   // them outside the strobe cycle shows it.
   task automatic access(input logic w, input logic [7:0] c,
                         input logic [15:0] d);
      @(posedge ref_clk);
      #1;
      req.wr    = w;
      req.rd    = ~w;
      req.cmd   = c;
      req.wdata = d;
      @(posedge ref_clk);
      #1;
      req.wr    = 1'b0;
      req.rd    = 1'b0;
      req.cmd   = ~c;
      req.wdata = ~d;
   endtask

endmodule

// File: sim/tb.sv
/*
 * Self-checking bench for the configuration register.
 * Assumes the host model file is compiled before this one.
 */
`timescale 1ns/1ps

module tb;
   import cor_pkg::*;

   localparam int unsigned SHIP = 20;

   logic        ref_clk;
   logic        rstn;
   logic        lpm;
   cor_req_s    req;
   cor_rsp_s    rsp;
   cor_ctrl_s   ctrl;
   int          err_total;
   int          checked;
   logic [15:0] word;
   logic [16:0] exp_q[$];

   cor_host_model i_cor_host_model (
      .ref_clk (ref_clk),
      .req     (req)
   );

   cor_config_reg #(.SHIP_CYCLES(SHIP)) i_cor_config_reg (
      .ref_clk        (ref_clk),
      .rstn           (rstn),
      .req            (req),
      .low_power_mode (lpm),
      .rsp            (rsp),
      .ctrl           (ctrl)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic cor_ctrl_s exp_ctrl(input logic [15:0] w,
                                          input logic lp);
      cor_ctrl_s c;
      c.battery_current_output_on   = w[15] & ~lp;
      c.system_power_output_on      = w[12] & ~lp;
      c.throttle_alert_source       = (w[14:13] == 2'h3) ? 2'h0 : w[14:13];
      c.input_shunt_select          = w[11];
      c.charge_shunt_select         = w[10];
      c.power_monitor_gain          = w[9];
      c.comparator_reference_select = w[7];
      c.comparator_polarity         = w[6];
      c.comparator_on               = |w[5:4];
      c.comparator_deglitch_select  = w[5:4];
      c.force_latchoff              = w[3];
      c.ship_discharge_active       = w[1];
      c.auto_wakeup_on              = w[0];
      return c;
   endfunction

   task automatic chk(input string nm, input logic [16:0] e,
                      input logic [16:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd(input logic [7:0] c, input logic [16:0] e);
      exp_q.push_back(e);
      i_cor_host_model.access(1'b0, c, 16'h0000);
   endtask

   task automatic wr_chk(input logic [15:0] w);
      i_cor_host_model.access(1'b1, COR_CMD_CONFIG, w);
      @(posedge ref_clk);
      #1;
      chk("ctrl", 17'(exp_ctrl(w, lpm)), 17'(ctrl));
      rd(COR_CMD_CONFIG, {1'b1, w});
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Reset image of the outputs and the register, looked at just after
   // release while the reset image still stands.
   task automatic reset_chk;
      logic [16:0] e;
      e = 17'(exp_ctrl(COR_CONFIG_RESET, 1'b0));
      chk("reset ctrl", e, 17'(ctrl));
      rd(COR_CMD_CONFIG, {1'b1, COR_CONFIG_RESET});
   endtask

   // Sets the ship discharge bit by one or more back-to-back writes and
   // counts the cycles for which the discharge output stands after the last.
   task automatic ship_count(input int writes);
      int   cnt;
      logic fin;
      cnt = 0;
      fin = 1'b0;
      repeat (writes) begin
         i_cor_host_model.access(1'b1, COR_CMD_CONFIG, COR_SHIP_MASK);
      end
      for (int k = 0; k < 100 && !fin; k++) begin
         @(posedge ref_clk);
         #1;
         if (ctrl.ship_discharge_active === 1'b1) begin
            cnt++;
         end else begin
            fin = 1'b1;
         end
      end
      if (!fin) begin
         err_total++;
         end_sim();
      end
      chk("ship cycles", 17'(SHIP), 17'(cnt));
   endtask

   // ****************************************************************
   // Read answers are matched against the oldest note.
   // ****************************************************************
   always @(negedge ref_clk) begin
      if (rsp.valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_total++;
            $display("wrong value answer expected none seen %h",
                     {rsp.hit, rsp.data});
         end else begin
            chk("read", exp_q.pop_front(), {rsp.hit, rsp.data});
         end
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rstn      = 1'b0;
      lpm       = 1'b0;
      err_total = 0;
      checked   = 0;
      void'($urandom(32'h12d0));
      repeat (12) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      reset_chk();
      // Alert codes are set with low power mode up, i.e. battery only.
      lpm = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr_chk({1'b0, i[1:0], 7'h00, i[1:0], 4'h0});
      end
      wr_chk(16'hfffd);
      lpm = 1'b0;
      wr_chk(16'hfffd);
      for (int i = 0; i < 16; i++) begin
         lpm  = 1'($urandom % 2);
         word = 16'($urandom) & ~COR_SHIP_MASK;
         wr_chk(word);
      end
      i_cor_host_model.access(1'b1, 8'h31, 16'h0000);
      rd(8'h31, 17'h00000);
      rd(COR_CMD_CONFIG, {1'b1, word});
      ship_count(1);
      rd(COR_CMD_CONFIG, 17'h10000);
      // A second write inside the window restarts it, so the count after
      // the last write is the full window again.
      ship_count(2);
      rd(COR_CMD_CONFIG, 17'h10000);
      // A reset in mid-run must bring back the reset word over stored data.
      wr_chk(16'hfffd);
      @(posedge ref_clk);
      #1;
      rstn = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      reset_chk();
      repeat (4) @(posedge ref_clk);
      chk("notes left", 17'h0, 17'(exp_q.size()));
      end_sim();
   end

endmodule
